// ### src/spp_pkg.sv
// constants and types for the secondary pci port control block
// Function
// [R1] high range: 66 or 33 MHz by double-speed
// [R2] low range: 50 or 25 MHz by double-speed
// [R3] seven clock outputs, each gated, all on
// [R4] pci clock input paces the pci core
// [R5] host disables all clocks for external source
// [R6] two tiers; bridge high, devices low after reset
// [R7] bit 7 of priority control parks bus
// [R8] six mask bits block device requests
// [R9] timeout flag after 16 unanswered pci clocks
// [R10] automatic masking; clearing bit drops auto masks
// [R11] classify configuration requests into three cases
// [R12] type 0 served locally, never forwarded
// [R13] secondary-bus request becomes pci type 0 cycle
// [R14] one-hot select line for devices 0 to 15
// [R15] further bus becomes pci type 1 cycle
// [R16] high tier first, round robin within tier
// [R17] granted device starts its transaction promptly
package spp_pkg;
  // configuration space offsets
  localparam logic [7:0] SPP_OFS_CLK_GATE = 8'hD8;
  localparam logic [7:0] SPP_OFS_ARB_PRIO = 8'hDC;
  localparam logic [7:0] SPP_OFS_ARB_BLOCK = 8'hDD;
  localparam logic [7:0] SPP_OFS_ARB_TOFLAG = 8'hDE;
  // reset values
  localparam logic [6:0] SPP_RST_CLK_GATE = 7'h7F;
  localparam logic [7:0] SPP_RST_ARB_PRIO = 8'h40;
  localparam logic [7:0] SPP_RST_ARB_BLOCK = 8'h00;
  // field positions
  localparam int SPP_PRIO_BRIDGE_BIT = 6;
  localparam int SPP_PRIO_PARK_BIT = 7;
  localparam int SPP_BLOCK_AUTO_BIT = 6;
  localparam int SPP_BLOCK_WATCH_BIT = 7;
  // agents: six devices plus the bridge as agent 6
  localparam int SPP_NUM_DEV = 6;
  localparam int SPP_NUM_AGENT = 7;
  localparam logic [2:0] SPP_BRIDGE_ID = 3'h6;
  localparam int SPP_NUM_CLK = 7;
  // grant timeout in pci clocks
  localparam logic [4:0] SPP_GNT_TIMEOUT_CLKS = 5'h10;
  // frequency codes {high_range, double_speed}
  localparam logic [1:0] SPP_FREQ_25 = 2'h0;
  localparam logic [1:0] SPP_FREQ_50 = 2'h1;
  localparam logic [1:0] SPP_FREQ_33 = 2'h2;
  localparam logic [1:0] SPP_FREQ_66 = 2'h3;
  // pci configuration address low bits
  localparam logic [1:0] SPP_CFG_T0_LOW = 2'h0;
  localparam logic [1:0] SPP_CFG_T1_LOW = 2'h1;
  // arbiter states
  typedef enum logic [1:0] {
    SPP_ST_IDLE = 2'b00,
    SPP_ST_GRANT = 2'b01,
    SPP_ST_BUSY = 2'b10
  } spp_arb_st_t;
endpackage

// ### src/spp_cfg_xlate.sv
// configuration request classifier and pci address builder
`timescale 1ns/1ps
module spp_cfg_xlate (
  // request fields
  input wire logic type1_i,
  input wire logic [7:0] bus_i,
  input wire logic [4:0] dev_i,
  input wire logic [2:0] func_i,
  input wire logic [5:0] reg_i,
  input wire logic [7:0] sec_bus_i,
  // classification and address
  output logic local_o,
  output logic pci_type1_o,
  output logic [31:0] addr_o
);
  import spp_pkg::*;

  // one-hot select line, none for devices 16 and up
  function automatic logic [15:0] idsel(input logic [4:0] dev);
    idsel = dev[4] ? 16'h0000 : (16'h0001 << dev[3:0]); // [R14]
  endfunction

  // three-way split by destination
  always_comb begin
    local_o = ~type1_i; // [R11] [R12]
    pci_type1_o = type1_i && (bus_i != sec_bus_i); // [R11]
    if (pci_type1_o) begin
      addr_o = {8'h00, bus_i, dev_i, func_i, reg_i, SPP_CFG_T1_LOW}; // [R15]
    end else if (type1_i) begin
      addr_o = {idsel(dev_i), 5'h00, func_i, reg_i, SPP_CFG_T0_LOW}; // [R13]
    end else begin
      addr_o = 32'h0000_0000; // local access drives nothing on the bus
    end
  end
endmodule

// ### src/spp_port_ctrl.sv
// secondary pci port control: clock gating, arbiter, config translation
`timescale 1ns/1ps
module spp_port_ctrl (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // configuration register port
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // clock pins
  input wire logic pci_clk_i,
  input wire logic high_range_freq_select_i,
  input wire logic double_speed_pin_i,
  output logic [1:0] freq_code_o,
  output logic [spp_pkg::SPP_NUM_CLK-1:0] clk_out_en_o,
  // arbitration pins
  input wire logic [spp_pkg::SPP_NUM_DEV-1:0] req_n_i,
  input wire logic frame_n_i,
  output logic [spp_pkg::SPP_NUM_DEV-1:0] gnt_n_o,
  // bridge's own master
  input wire logic bridge_req_i,
  output logic bridge_gnt_o,
  // configuration translation request
  input wire logic xlate_req_i,
  input wire logic xlate_type1_i,
  input wire logic [7:0] xlate_bus_i,
  input wire logic [4:0] xlate_dev_i,
  input wire logic [2:0] xlate_func_i,
  input wire logic [5:0] xlate_reg_i,
  input wire logic [7:0] sec_bus_i,
  output logic xlate_valid_o,
  output logic xlate_local_o,
  output logic xlate_pci_type1_o,
  output logic [31:0] xlate_addr_o
);
  import spp_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic [6:0] clk_gate;
    logic [7:0] prio;
    logic [7:0] block;
    logic [5:0] toflag;
    logic [5:0] amask;
    spp_arb_st_t st;
    logic [2:0] owner;
    logic [2:0] last;
    logic [4:0] cnt;
    logic [5:0] gnt_n;
    logic bgnt;
    logic [2:0] pclk_s;
    logic [1:0] frm_s;
    logic [5:0] req_s1;
    logic [5:0] req_s2;
    logic [1:0] hr_s;
    logic [1:0] ds_s;
    logic [1:0] freq;
    logic [7:0] rdata;
    logic xv;
    logic xl;
    logic xt1;
    logic [31:0] xaddr;
  } spp_state_t;

  spp_state_t s_r;
  spp_state_t s_nxt;
  logic x_local; // translator outputs
  logic x_t1;
  logic [31:0] x_addr;
  logic [6:0] want; // live requests incl. bridge
  logic [6:0] want_hi; // requests in the high tier
  logic pclk_rise; // edge of the sampled pci clock
  logic [2:0] pick; // arbitration winner

  // next agent after last that requests, rotating
  function automatic logic [2:0] rr_pick(input logic [6:0] v, input logic [2:0] last);
    logic [2:0] idx;
    rr_pick = last;
    for (int i = 7; i >= 1; i--) begin
      idx = 3'((int'(last) + i) % SPP_NUM_AGENT);
      if (v[idx]) begin
        rr_pick = idx;
      end
    end
  endfunction

  spp_cfg_xlate u_xlate (
    .type1_i(xlate_type1_i),
    .bus_i(xlate_bus_i),
    .dev_i(xlate_dev_i),
    .func_i(xlate_func_i),
    .reg_i(xlate_reg_i),
    .sec_bus_i(sec_bus_i),
    .local_o(x_local),
    .pci_type1_o(x_t1),
    .addr_o(x_addr)
  );

  // request vectors; masked devices never reach arbitration
  assign want = {bridge_req_i, ~s_r.req_s2 & ~s_r.block[5:0] & ~s_r.amask}; // [R8] [R10]
  assign want_hi = want & {s_r.prio[SPP_PRIO_BRIDGE_BIT], s_r.prio[5:0]}; // [R6]
  assign pick = rr_pick((want_hi != 7'h00) ? want_hi : want, s_r.last); // [R16]
  // pci core paced by the incoming clock, seen through a synchroniser
  assign pclk_rise = s_r.pclk_s[1] & ~s_r.pclk_s[2]; // [R4]

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    // pin synchronisers; stage one feeds only stage two
    s_nxt.pclk_s = {s_r.pclk_s[1:0], pci_clk_i};
    s_nxt.frm_s = {s_r.frm_s[0], frame_n_i};
    s_nxt.req_s1 = req_n_i; // pins stay active low through both flops
    s_nxt.req_s2 = s_r.req_s1;
    s_nxt.hr_s = {s_r.hr_s[0], high_range_freq_select_i};
    s_nxt.ds_s = {s_r.ds_s[0], double_speed_pin_i};
    // frequency select from the two straps
    if (s_r.hr_s[1]) begin
      s_nxt.freq = s_r.ds_s[1] ? SPP_FREQ_66 : SPP_FREQ_33; // [R1]
    end else begin
      s_nxt.freq = s_r.ds_s[1] ? SPP_FREQ_50 : SPP_FREQ_25; // [R2]
    end
    // register writes
    if (cfg_wr_i) begin
      case (cfg_addr_i)
        SPP_OFS_CLK_GATE: s_nxt.clk_gate = cfg_wdata_i[6:0]; // [R3] [R5]
        SPP_OFS_ARB_PRIO: s_nxt.prio = cfg_wdata_i; // [R6] [R7]
        SPP_OFS_ARB_BLOCK: s_nxt.block = cfg_wdata_i; // [R8]
        default: ;
      endcase
    end
    // dropping auto mask enable frees every auto mask
    if (!s_nxt.block[SPP_BLOCK_AUTO_BIT]) begin
      s_nxt.amask = 6'h00; // [R10]
    end
    // flags are kept only while the watch is on
    if (!s_nxt.block[SPP_BLOCK_WATCH_BIT]) begin
      s_nxt.toflag = 6'h00;
    end
    // arbiter
    case (s_r.st)
      SPP_ST_IDLE: begin
        s_nxt.gnt_n = 6'h3F;
        s_nxt.bgnt = 1'b0;
        s_nxt.cnt = 5'h00;
        if (want != 7'h00) begin
          // only grant while the bus is idle
          if (s_r.frm_s[1]) begin
            s_nxt.st = SPP_ST_GRANT;
            s_nxt.owner = pick;
            s_nxt.last = pick; // [R16]
            if (pick == SPP_BRIDGE_ID) begin
              s_nxt.bgnt = 1'b1;
            end else begin
              s_nxt.gnt_n[pick] = 1'b0;
            end
          end
        end else if (s_r.prio[SPP_PRIO_PARK_BIT]) begin
          s_nxt.bgnt = 1'b1; // idle bus parked on the bridge [R7]
        end
      end
      SPP_ST_GRANT: begin
        if (!s_r.frm_s[1]) begin
          // owner started; grant may go
          s_nxt.st = SPP_ST_BUSY;
          s_nxt.gnt_n = 6'h3F;
          s_nxt.bgnt = 1'b0;
        end else if (!want[s_r.owner]) begin
          s_nxt.st = SPP_ST_IDLE; // request withdrawn before start
          s_nxt.gnt_n = 6'h3F;
          s_nxt.bgnt = 1'b0;
        end else if (pclk_rise) begin
          s_nxt.cnt = s_r.cnt + 5'h01;
          // device silent for the whole window
          if (s_nxt.cnt == SPP_GNT_TIMEOUT_CLKS) begin // [R9] [R17]
            s_nxt.st = SPP_ST_IDLE;
            s_nxt.gnt_n = 6'h3F;
            s_nxt.bgnt = 1'b0;
            if (s_r.owner != SPP_BRIDGE_ID) begin
              if (s_nxt.block[SPP_BLOCK_WATCH_BIT]) begin
                s_nxt.toflag[s_r.owner] = 1'b1; // [R9]
              end
              if (s_nxt.block[SPP_BLOCK_AUTO_BIT]) begin
                s_nxt.amask[s_r.owner] = 1'b1; // [R10]
              end
            end
          end
        end
      end
      SPP_ST_BUSY: begin
        if (s_r.frm_s[1]) begin
          s_nxt.st = SPP_ST_IDLE;
        end
      end
      default: s_nxt.st = SPP_ST_IDLE;
    endcase
    // read data, one cycle behind the address
    case (cfg_addr_i)
      SPP_OFS_CLK_GATE: s_nxt.rdata = {1'b0, s_r.clk_gate};
      SPP_OFS_ARB_PRIO: s_nxt.rdata = s_r.prio;
      SPP_OFS_ARB_BLOCK: s_nxt.rdata = s_r.block;
      SPP_OFS_ARB_TOFLAG: s_nxt.rdata = {2'b00, s_r.toflag};
      default: s_nxt.rdata = 8'h00;
    endcase
    // configuration translation result, registered
    s_nxt.xv = xlate_req_i;
    if (xlate_req_i) begin
      s_nxt.xl = x_local; // [R12]
      s_nxt.xt1 = x_t1;
      s_nxt.xaddr = x_addr;
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
      s_r.clk_gate <= SPP_RST_CLK_GATE; // [R3]
      s_r.prio <= SPP_RST_ARB_PRIO; // [R6]
      s_r.block <= SPP_RST_ARB_BLOCK;
      s_r.st <= SPP_ST_IDLE;
      s_r.gnt_n <= 6'h3F;
      s_r.frm_s <= 2'h3;
      s_r.req_s1 <= 6'h3F; // request pins idle high, so no false request
      s_r.req_s2 <= 6'h3F;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state
  assign cfg_rdata_o = s_r.rdata;
  assign freq_code_o = s_r.freq;
  assign clk_out_en_o = s_r.clk_gate;
  assign gnt_n_o = s_r.gnt_n;
  assign bridge_gnt_o = s_r.bgnt;
  assign xlate_valid_o = s_r.xv;
  assign xlate_local_o = s_r.xl;
  assign xlate_pci_type1_o = s_r.xt1;
  assign xlate_addr_o = s_r.xaddr;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // at most one agent granted
  AST_ONE_GRANT: assert property ($onehot0({~gnt_n_o, bridge_gnt_o})) // [R16]
    else $error("more than one grant");
  // frequency follows the synced straps
  AST_FREQ: assert property (s_r.hr_s[1] && s_r.ds_s[1] |=> freq_code_o == SPP_FREQ_66) // [R1]
    else $error("frequency code not 66");
  AST_FREQ_LOW: assert property (!s_r.hr_s[1] && !s_r.ds_s[1] // [R2]
    |=> freq_code_o == SPP_FREQ_25)
    else $error("frequency code not 25");
  // clock gate write lands next cycle
  AST_CLK_GATE: assert property (cfg_wr_i && cfg_addr_i == SPP_OFS_CLK_GATE // [R3]
    |=> clk_out_en_o == $past(cfg_wdata_i[6:0]))
    else $error("clock gate not written");
  // a blocked device is never newly granted
  AST_MASKED: assert property ((s_r.block[5:0] & gnt_n_o) != 6'h00 // [R8]
    |=> (~gnt_n_o & $past(s_r.block[5:0] & gnt_n_o)) == 6'h00)
    else $error("blocked device granted");
  // timeout raises the owner's flag
  AST_TIMEOUT: assert property (s_r.st == SPP_ST_GRANT && pclk_rise && s_r.frm_s[1] // [R9]
    && want[s_r.owner] && s_r.cnt == 5'h0F && s_r.owner != SPP_BRIDGE_ID
    && s_r.block[SPP_BLOCK_WATCH_BIT] && !cfg_wr_i
    |=> s_r.toflag[s_r.owner] && gnt_n_o == 6'h3F)
    else $error("timeout flag missing");
  // clearing auto bit frees masks
  AST_AUTOCLR: assert property (!s_r.block[SPP_BLOCK_AUTO_BIT] |-> s_r.amask == 6'h00) // [R10]
    else $error("auto mask survives disable");
  // high tier beats low tier
  AST_HIGH_FIRST: assert property (s_r.st == SPP_ST_IDLE && s_r.frm_s[1] // [R6] [R16]
    && want_hi != 7'h00
    |=> s_r.st == SPP_ST_GRANT && ($past(want_hi) & (7'h01 << s_r.owner)) != 7'h00)
    else $error("low tier beat high tier");
  // type 0 never forwarded; select lines one-hot or empty
  AST_XLATE: assert property (xlate_req_i && !xlate_type1_i // [R12]
    |=> xlate_local_o && !xlate_pci_type1_o)
    else $error("type 0 request forwarded");
  AST_IDSEL: assert property (xlate_valid_o && !xlate_local_o && !xlate_pci_type1_o // [R13] [R14]
    |-> $onehot0(xlate_addr_o[31:16]) && xlate_addr_o[1:0] == SPP_CFG_T0_LOW)
    else $error("bad type 0 address");
  AST_TYPE1: assert property (xlate_valid_o && xlate_pci_type1_o // [R15]
    |-> xlate_addr_o[1:0] == SPP_CFG_T1_LOW && xlate_addr_o[31:24] == 8'h00)
    else $error("bad type 1 address");
endmodule

// ### bench/spp_dev_model.sv
// behavioural model of the six pci devices on the secondary bus
`timescale 1ns/1ps
module spp_dev_model (
  // clock
  input wire logic clk_i,
  // bench controls: wish to use the bus, ignore grant, answer delay
  input wire logic [5:0] want_i,
  input wire logic [5:0] mute_i,
  input wire logic [3:0] lat_i,
  // bus pins
  input wire logic [5:0] gnt_n_i,
  output logic [5:0] req_n_o,
  output logic frame_n_o
);
  logic [4:0] busy_r = 5'h00; // cycles left in the current transfer
  logic frame_r = 1'b1; // frame line, idle at its pull-up
  // a request pin mirrors the wish; an idle pin sits at its pull-up
  assign req_n_o = ~want_i;
  assign frame_n_o = frame_r;
  // a granted, willing device keeps frame high lat_i+1 more cycles, then holds it low four cycles
  always @(posedge clk_i) begin
    if (busy_r != 5'h00) begin
      busy_r <= busy_r - 5'h01;
      frame_r <= (busy_r > 5'h05) || (busy_r == 5'h01);
    end else if ((~gnt_n_i & want_i & ~mute_i) != 6'h00) begin
      busy_r <= {1'b0, lat_i} + 5'h06;
    end
  end
endmodule

// ### bench/tb_top.sv
// self-checking bench for the secondary pci port control block
`timescale 1ns/1ps
module tb_top;
  import spp_pkg::*;
  `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
  int num_errors = 0;
  int samples_checked = 0;
  logic clk = 0, rstn = 0, pclk = 0, wr = 0, hsel = 1, dsp = 1, breq = 0;
  logic [7:0] addr = 0, wd = 0, rd, xbus = 0, sec = 8'h05;
  logic [1:0] fq;
  logic [6:0] cken;
  logic [5:0] want = 0, mute = 0, req_n, gnt_n;
  logic [3:0] lat = 0;
  logic frame_n, bgnt, xr = 0, xt1 = 0, xv, xl, xp1;
  logic [4:0] xdev = 0;
  logic [2:0] xfn = 0;
  logic [5:0] xreg = 0;
  logic [31:0] xa;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  time t0; // grant time, then grant span less one system cycle, in the timeout scenario
  // expected frequency code indexed by {high range, double speed}
  logic [1:0] fexp [4] = '{SPP_FREQ_25, SPP_FREQ_50, SPP_FREQ_33, SPP_FREQ_66};
  initial forever #12.5 clk = ~clk;
  // pci clock runs at one eighth of the system clock rate, its edges on system clock falling edges
  initial forever #100 pclk = ~pclk;
  spp_port_ctrl dut (.sys_clk_i(clk), .rstn_i(rstn), .cfg_wr_i(wr), .cfg_addr_i(addr),
    .cfg_wdata_i(wd), .cfg_rdata_o(rd), .pci_clk_i(pclk), .high_range_freq_select_i(hsel),
    .double_speed_pin_i(dsp), .freq_code_o(fq), .clk_out_en_o(cken), .req_n_i(req_n),
    .frame_n_i(frame_n), .gnt_n_o(gnt_n), .bridge_req_i(breq), .bridge_gnt_o(bgnt),
    .xlate_req_i(xr), .xlate_type1_i(xt1), .xlate_bus_i(xbus), .xlate_dev_i(xdev),
    .xlate_func_i(xfn), .xlate_reg_i(xreg), .sec_bus_i(sec), .xlate_valid_o(xv),
    .xlate_local_o(xl), .xlate_pci_type1_o(xp1), .xlate_addr_o(xa));
  spp_dev_model devs (.clk_i(clk), .want_i(want), .mute_i(mute), .lat_i(lat),
    .gnt_n_i(gnt_n), .req_n_o(req_n), .frame_n_o(frame_n));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 0;
  endtask
  // read data lags the offset by one cycle
  task automatic rreg(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    `CHK("cfg_rdata", x, rd)
  endtask
  // wait for grant bit d (6 = bridge, 7 = frame line) to reach v, bounded
  task automatic till(input int d, input logic v);
    logic [7:0] ag;
    int n;
    n = 0;
    ag = {frame_n, bgnt, ~gnt_n};
    while (ag[d] !== v && n < 400) begin
      @(negedge clk);
      ag = {frame_n, bgnt, ~gnt_n};
      n++;
    end
    `CHK("grant or frame", v, ag[d])
  endtask
  // one whole bus transfer by device d
  task automatic xfer(input int d);
    want[d] = 1;
    till(d, 1);
    till(7, 0);
    want[d] = 0;
    till(7, 1);
  endtask
  // expected translation result {local, type1, address}
  function automatic logic [33:0] xexp();
    if (!xt1) return 34'h2_0000_0000;
    if (xbus != sec) return {2'b01, 8'h00, xbus, xdev, xfn, xreg, SPP_CFG_T1_LOW};
    return {2'b00, (xdev[4] ? 16'h0000 : 16'h0001 << xdev[3:0]), 5'h00, xfn, xreg, 2'h0};
  endfunction
  // results are paired with the oldest expectation as they appear
  always @(negedge clk) begin
    if (xv === 1'b1) begin
      e = exp_q.pop_front();
      `CHK("xlate", e, {xl, xp1, xa})
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h8719));
    repeat (4) @(negedge clk);
    rstn = 1;
    rreg(SPP_OFS_CLK_GATE, 8'h7F);
    rreg(SPP_OFS_ARB_PRIO, SPP_RST_ARB_PRIO);
    rreg(SPP_OFS_ARB_BLOCK, 8'h00);
    rreg(SPP_OFS_ARB_TOFLAG, 8'h00);
    rreg(8'h80, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wd = 8'($urandom) & 8'h7F;
      wreg(SPP_OFS_CLK_GATE, wd);
      `CHK("clk_out_en", wd[6:0], cken)
    end
    wreg(SPP_OFS_CLK_GATE, 8'h00);
    `CHK("clk_out_en", 7'h00, cken)
    wreg(SPP_OFS_CLK_GATE, 8'h7F);
    wreg(SPP_OFS_ARB_TOFLAG, 8'hFF);
    rreg(SPP_OFS_ARB_TOFLAG, 8'h00);
    $display("done registers");
    for (int i = 0; i < 4; i++) begin
      {hsel, dsp} = 2'(i);
      repeat (5) @(negedge clk);
      `CHK("freq_code", fexp[i], fq)
    end
    $display("done frequency");
    for (int i = 0; i < 48; i++) begin
      @(negedge clk);
      xr = 1;
      xt1 = (i % 5) != 0;
      xbus = (i % 3 == 0) ? 8'($urandom) : sec;
      xdev = (i < 32) ? 5'(i) : 5'($urandom);
      xfn = 3'($urandom);
      xreg = 6'($urandom);
      exp_q.push_back(xexp());
    end
    @(negedge clk);
    xr = 0;
    repeat (3) @(negedge clk);
    `CHK("xlate pending", 0, exp_q.size())
    $display("done translation");
    xfer(2);
    want[1] = 1;
    breq = 1;
    till(6, 1);
    `CHK("gnt_n 1", 1'b1, gnt_n[1])
    breq = 0;
    xfer(1);
    wreg(SPP_OFS_ARB_PRIO, 8'h50);
    want = 6'h12;
    till(4, 1);
    `CHK("gnt_n 1", 1'b1, gnt_n[1])
    xfer(4);
    xfer(1);
    wreg(SPP_OFS_ARB_PRIO, 8'h40);
    wreg(SPP_OFS_ARB_BLOCK, 8'h04);
    want[2] = 1;
    repeat (30) @(negedge clk);
    `CHK("gnt_n 2", 1'b1, gnt_n[2])
    wreg(SPP_OFS_ARB_BLOCK, 8'h00);
    xfer(2);
    // same tier, last grant went to 2: rotation reaches 5 before 1
    want = 6'h22;
    till(5, 1);
    `CHK("gnt_n 1", 1'b1, gnt_n[1])
    xfer(5);
    xfer(1);
    $display("done arbitration");
    wreg(SPP_OFS_ARB_BLOCK, 8'hC0);
    mute[3] = 1;
    want[3] = 1;
    till(3, 1);
    t0 = $time;
    till(3, 0);
    // 121 to 128 system cycles; less one cycle that is 15 whole pci clocks
    t0 = $time - t0 - 25;
    `CHK("timeout span", SPP_GNT_TIMEOUT_CLKS - 1, t0 / 200)
    rreg(SPP_OFS_ARB_TOFLAG, 8'h08);
    repeat (30) @(negedge clk);
    `CHK("gnt_n 3", 1'b1, gnt_n[3])
    mute[3] = 0;
    wreg(SPP_OFS_ARB_BLOCK, 8'h80);
    xfer(3);
    lat = 4'h8;
    xfer(5);
    rreg(SPP_OFS_ARB_TOFLAG, 8'h08);
    $display("done timeout");
    wreg(SPP_OFS_ARB_PRIO, 8'hC0);
    repeat (10) @(negedge clk);
    `CHK("bridge_gnt", 1'b1, bgnt)
    wreg(SPP_OFS_ARB_PRIO, 8'h40);
    repeat (10) @(negedge clk);
    `CHK("bridge_gnt", 1'b0, bgnt)
    $display("done parking");
    report_and_stop();
  end
endmodule
